// *** hw/crhc_defines.vh ***
// constants for the console run/halt control block
`ifndef CRHC_DEFINES_VH
`define CRHC_DEFINES_VH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define CRHC_OFS_CTRL 8'h00
`define CRHC_OFS_STAT 8'h04
`define CRHC_OFS_MEMORY_PARITY_ERROR_REGISTER 8'h08
`define CRHC_OFS_PROCESSOR_PARITY_ERROR_REGISTER 8'h0c
`define CRHC_OFS_LAMP 8'h10
`define CRHC_OFS_SEL 8'h14
// ----------------------------------------------------------------
// console control register bits
// ----------------------------------------------------------------
`define CRHC_CC_STATE 0
`define CRHC_CC_IRQ 3
`define CRHC_CC_W 4
// ----------------------------------------------------------------
// widths and counts
// ----------------------------------------------------------------
`define CRHC_DW 24
`define CRHC_GRP_W 4
`define CRHC_SEL_W 3
`define CRHC_SEL_MAX 3'h6
`define CRHC_SEL_MEM 3'h6
`define CRHC_DEB_NS 1000
`define CRHC_CLK_MHZ 125
`define CRHC_DEB_CYC 8'h7d // 1000 ns at 125 MHz
`define CRHC_DEB_W 8
// ----------------------------------------------------------------
// axi responses
// ----------------------------------------------------------------
`define CRHC_RESP_OK 2'h0
`define CRHC_RESP_ERR 2'h2
`endif

// *** hw/crhc_console.v ***
// console run/halt control with axi4-lite register access
//
// Chosen here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "crhc_defines.vh"
// Contract
// - interrupt button press sets control bit 3 and lights its lamp.
// - each source-mode press toggles cassette/memory source and lamps, unless an examine clear in the same cycle forces memory source.
// - cassette fetch only if cassette source and cassette assigned.
// - clear ignored in run; in examine it resets registers and flops.
// - start enters run; also pulses cassette start if cassette source.
// - test lamp: interrupt pressed, single step, or source not normal.
// - data lamps register the exchange every cycle, in examine and in run.
// - state lamp equals control register bit 0.
// - run lamp lit exactly in run and stop states.
// - error lamp is or of both parity error registers.
// - start or load zeroes both parity error registers.
// - load writes the 24 data switches into the selected target.
// - interrupt toggle sets bit while up, down never clears it.
// - free running: run until console or micro halt, then examine.
// - single step: run one microinstruction then back to examine.
// - 16 group by 7 select positions decode 112 selections.
// - halt waits for the current microinstruction to complete.
// - load and increment strobes act only in examine state; a load press in run still zeroes the parity error registers.
module crhc_console (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // axi4-lite write address
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   // axi4-lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   // axi4-lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // axi4-lite read address
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   // axi4-lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // panel pushbuttons, raw, active high
   input wire interrupt_request_button,
   input wire source_mode_button,
   input wire clear_button,
   input wire start_button,
   input wire halt_button,
   input wire load_button,
   input wire inc_button,
   // panel switches
   input wire interrupt_toggle,
   input wire single_step_select,
   input wire micro_source_normal,
   input wire cassette_to_processor,
   input wire [`CRHC_DW-1:0] data_switches,
   input wire [`CRHC_GRP_W-1:0] group_select,
   input wire [`CRHC_SEL_W-1:0] register_select,
   // processor core exchange
   input wire [`CRHC_DW-1:0] main_exchange,
   input wire micro_done,
   input wire micro_halt,
   input wire mem_parity_err,
   input wire proc_parity_err,
   input wire [`CRHC_DW-1:0] mem_parity_bits,
   input wire [`CRHC_DW-1:0] proc_parity_bits,
   output reg run_enable,
   output reg cassette_start,
   output wire fetch_from_cassette,
   output reg clear_pulse,
   output reg load_pulse,
   output reg inc_pulse,
   output reg [`CRHC_DW-1:0] load_data,
   output reg [6:0] load_target,
   output reg select_valid,
   // lamps
   output wire interrupt_lamp,
   output wire cassette_lamp,
   output wire memory_lamp,
   output wire test_state_lamp,
   output reg [`CRHC_DW-1:0] data_lamps,
   output wire state_lamp,
   output wire run_lamp,
   output wire error_lamp
);

// ----------------------------------------------------------------
// run control states
// ----------------------------------------------------------------
localparam ST_EXAM = 2'h0;
localparam ST_RUN = 2'h1;
localparam ST_STOP = 2'h2;

localparam NB = 7;
localparam [`CRHC_DEB_W-1:0] DEB_CYC = `CRHC_DEB_CYC;

// selection index, group times seven plus select
function [6:0] sel_index;
   input [`CRHC_GRP_W-1:0] g;
   input [`CRHC_SEL_W-1:0] s;
   begin
      sel_index = {g, 3'h0} - {3'h0, g} + {4'h0, s};
   end
endfunction

// ----------------------------------------------------------------
// button conditioning
// ----------------------------------------------------------------
wire [NB-1:0] raw_btn;
reg [NB-1:0] sync1_q;
reg [NB-1:0] sync2_q;
reg [NB-1:0] stable_q;
reg [NB-1:0] stable_d1_q;
reg [`CRHC_DEB_W-1:0] deb_cnt_q [0:NB-1];
wire [NB-1:0] press;
integer i;

assign raw_btn = {inc_button, load_button, halt_button, start_button,
   clear_button, source_mode_button, interrupt_request_button};

// two flops, then a hold-off counter so contact bounce never doubles
always @(posedge aclk) begin
   if (!aresetn) begin
      sync1_q <= {NB{1'b0}};
      sync2_q <= {NB{1'b0}};
      stable_q <= {NB{1'b0}};
      stable_d1_q <= {NB{1'b0}};
      for (i = 0; i < NB; i = i + 1)
         deb_cnt_q[i] <= {`CRHC_DEB_W{1'b0}};
   end else begin
      sync1_q <= raw_btn;
      sync2_q <= sync1_q;
      stable_d1_q <= stable_q;
      for (i = 0; i < NB; i = i + 1) begin
         if (sync2_q[i] == stable_q[i])
            deb_cnt_q[i] <= {`CRHC_DEB_W{1'b0}};
         else if (deb_cnt_q[i] == DEB_CYC - 1'b1) begin
            stable_q[i] <= sync2_q[i];
            deb_cnt_q[i] <= {`CRHC_DEB_W{1'b0}};
         end else
            deb_cnt_q[i] <= deb_cnt_q[i] + 1'b1;
      end
   end
end

assign press = stable_q & ~stable_d1_q;

wire p_irq = press[0];
wire p_mode = press[1];
wire p_clear = press[2];
wire p_start = press[3];
wire p_halt = press[4];
wire p_load = press[5];
wire p_inc = press[6];

// ----------------------------------------------------------------
// run/examine state machine
// ----------------------------------------------------------------
reg [1:0] state_q;
reg [1:0] state_d;
wire in_exam = (state_q == ST_EXAM);
wire in_run = (state_q != ST_EXAM);

always @* begin
   state_d = state_q;
   case (state_q)
      ST_EXAM: begin
         if (p_start)
            state_d = ST_RUN;
      end
      ST_RUN: begin
         // halt requests wait for the microinstruction boundary
         if (micro_halt && micro_done)
            state_d = ST_EXAM;
         else if (p_halt || single_step_select)
            state_d = ST_STOP;
      end
      ST_STOP: begin
         if (micro_done)
            state_d = ST_EXAM;
      end
      default: state_d = ST_EXAM;
   endcase
end

always @(posedge aclk) begin
   if (!aresetn)
      state_q <= ST_EXAM;
   else
      state_q <= state_d;
end

// ----------------------------------------------------------------
// console control bits, source mode and parity registers
// ----------------------------------------------------------------
reg [`CRHC_CC_W-1:0] cc_q;
reg cassette_src_q;
reg irq_pressed_q;
reg [`CRHC_DW-1:0] memory_parity_error_register_q;
reg [`CRHC_DW-1:0] processor_parity_error_register_q;
wire sw_wr_ctrl;
wire [31:0] sw_wdata;
wire clear_ok = p_clear && in_exam;

always @(posedge aclk) begin
   if (!aresetn) begin
      cc_q <= {`CRHC_CC_W{1'b0}};
      cassette_src_q <= 1'b0;
      irq_pressed_q <= 1'b0;
   end else begin
      if (clear_ok)
         cc_q <= {`CRHC_CC_W{1'b0}};
      else if (sw_wr_ctrl)
         cc_q <= sw_wdata[`CRHC_CC_W-1:0];
      // hardware set wins over a software write or a clear
      if (p_irq || interrupt_toggle)
         cc_q[`CRHC_CC_IRQ] <= 1'b1;
      if (p_irq)
         irq_pressed_q <= 1'b1;
      else if (clear_ok || !cc_q[`CRHC_CC_IRQ])
         irq_pressed_q <= 1'b0;
      if (p_mode || clear_ok)
         cassette_src_q <= ~cassette_src_q & ~clear_ok;
   end
end

// start or load wipes the error registers; a same-cycle error still lands
wire par_wipe = p_start || p_load || clear_ok;
wire [`CRHC_DW-1:0] memory_parity_error_register_keep = par_wipe ? {`CRHC_DW{1'b0}} : memory_parity_error_register_q;
wire [`CRHC_DW-1:0] processor_parity_error_register_keep = par_wipe ? {`CRHC_DW{1'b0}} : processor_parity_error_register_q;
always @(posedge aclk) begin
   if (!aresetn) begin
      memory_parity_error_register_q <= {`CRHC_DW{1'b0}};
      processor_parity_error_register_q <= {`CRHC_DW{1'b0}};
   end else begin
      memory_parity_error_register_q <= memory_parity_error_register_keep | (mem_parity_bits & {`CRHC_DW{mem_parity_err}});
      processor_parity_error_register_q <= processor_parity_error_register_keep | (proc_parity_bits & {`CRHC_DW{proc_parity_err}});
   end
end

// ----------------------------------------------------------------
// core strobes and data lamps
// ----------------------------------------------------------------
wire [6:0] sel_idx = sel_index(group_select, register_select);
wire sel_ok = (register_select <= `CRHC_SEL_MAX);

always @(posedge aclk) begin
   if (!aresetn) begin
      run_enable <= 1'b0;
      cassette_start <= 1'b0;
      clear_pulse <= 1'b0;
      load_pulse <= 1'b0;
      inc_pulse <= 1'b0;
      load_data <= {`CRHC_DW{1'b0}};
      load_target <= 7'h00;
      select_valid <= 1'b0;
      data_lamps <= {`CRHC_DW{1'b0}};
   end else begin
      run_enable <= (state_d != ST_EXAM);
      cassette_start <= p_start && in_exam && cassette_src_q;
      clear_pulse <= clear_ok;
      load_pulse <= p_load && in_exam && sel_ok;
      inc_pulse <= p_inc && in_exam &&
         (register_select == `CRHC_SEL_MEM);
      load_target <= sel_idx;
      select_valid <= sel_ok;
      if (p_load && in_exam)
         load_data <= data_switches;
      // examine: exchange holds the selection; run: lamps flicker
      data_lamps <= main_exchange;
   end
end

// ----------------------------------------------------------------
// lamps
// ----------------------------------------------------------------
assign interrupt_lamp = cc_q[`CRHC_CC_IRQ];
assign cassette_lamp = cassette_src_q;
assign memory_lamp = ~cassette_src_q;
assign fetch_from_cassette = cassette_src_q && cassette_to_processor;
assign test_state_lamp = irq_pressed_q || single_step_select ||
   !micro_source_normal;
assign state_lamp = cc_q[`CRHC_CC_STATE];
assign run_lamp = in_run;
assign error_lamp = (|memory_parity_error_register_q) || (|processor_parity_error_register_q);

// ----------------------------------------------------------------
// axi4-lite slave, one write and one read at a time
// ----------------------------------------------------------------
reg aw_got_q;
reg w_got_q;
reg [7:0] awaddr_q;
reg [31:0] wdata_q;
reg s_axi_wstrb_ok;
wire wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;

assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
assign s_axi_wready = !w_got_q && !s_axi_bvalid;
assign s_axi_arready = !s_axi_rvalid;
assign sw_wr_ctrl = wr_fire && (awaddr_q == `CRHC_OFS_CTRL) &&
   s_axi_wstrb_ok;
assign sw_wdata = wdata_q;

always @(posedge aclk) begin
   if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      s_axi_wstrb_ok <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CRHC_RESP_OK;
   end else begin
      if (s_axi_awvalid && s_axi_awready) begin
         aw_got_q <= 1'b1;
         awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_got_q <= 1'b1;
         wdata_q <= s_axi_wdata;
         s_axi_wstrb_ok <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (awaddr_q == `CRHC_OFS_CTRL) ?
            `CRHC_RESP_OK : `CRHC_RESP_ERR;
      end else if (s_axi_bvalid && s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end
end

// read mux, unmapped addresses answer slverr with zero data
always @(posedge aclk) begin
   if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `CRHC_RESP_OK;
   end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `CRHC_RESP_OK;
      case (s_axi_araddr)
         `CRHC_OFS_CTRL: s_axi_rdata <= {28'h0000000, cc_q};
         `CRHC_OFS_STAT: s_axi_rdata <= {26'h0000000, fetch_from_cassette,
            cassette_src_q, test_state_lamp, error_lamp, state_q};
         `CRHC_OFS_MEMORY_PARITY_ERROR_REGISTER: s_axi_rdata <= {8'h00, memory_parity_error_register_q};
         `CRHC_OFS_PROCESSOR_PARITY_ERROR_REGISTER: s_axi_rdata <= {8'h00, processor_parity_error_register_q};
         `CRHC_OFS_LAMP: s_axi_rdata <= {8'h00, data_lamps};
         `CRHC_OFS_SEL: s_axi_rdata <= {24'h000000, select_valid,
            load_target};
         default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `CRHC_RESP_ERR;
         end
      endcase
   end else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
end

endmodule // crhc_console

// *** tb/crhc_console_monitor.sv ***
// concurrent checks on the console run/halt control ports
`timescale 1ns/10ps
module crhc_console_monitor (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // panel switches
   input wire cassette_to_processor,
   input wire single_step_select,
   input wire interrupt_toggle,
   // core side
   input wire run_enable,
   input wire cassette_start,
   input wire fetch_from_cassette,
   input wire clear_pulse,
   input wire load_pulse,
   // lamps
   input wire run_lamp,
   input wire cassette_lamp,
   input wire memory_lamp,
   input wire test_state_lamp,
   input wire interrupt_lamp
);
   // ------------------------------------------------------------
   // assertions, one clock domain
   // ------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_run_lamp_eq: assert property (run_lamp == run_enable)
      else $error("run lamp differs from run state");
   a_src_lamps_excl: assert property (cassette_lamp != memory_lamp)
      else $error("source lamps not exclusive");
   a_fetch_needs_cas: assert property (fetch_from_cassette |-> cassette_lamp)
      else $error("cassette fetch without cassette source");
   // four cycles of margin; the switch reaches the fetch output unsynchronised
   a_fetch_unassigned: assert property
      ((!cassette_to_processor) [*4] |-> !fetch_from_cassette)
      else $error("cassette fetch while unassigned");
   a_test_on_step: assert property
      (single_step_select [*4] |-> test_state_lamp)
      else $error("test lamp dark in single step");
   a_cas_start_src: assert property
      (cassette_start |-> cassette_lamp ##1 !cassette_start)
      else $error("cassette start bad");
   a_load_examine: assert property (load_pulse |-> !run_enable)
      else $error("load acted in run");
   a_clear_examine: assert property (clear_pulse |-> !run_enable)
      else $error("clear acted in run");
   a_irq_hold_down: assert property
      ($fell(interrupt_toggle) && interrupt_lamp |=> interrupt_lamp [*3])
      else $error("toggle down cleared request");
endmodule // crhc_console_monitor

bind crhc_console crhc_console_monitor u_crhc_console_monitor (.*);

// *** tb/crhc_core_model.sv ***
// behavioural processor core facing the console block
`timescale 1ns/10ps
module crhc_core_model (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // console side
   input wire run_enable,
   output logic micro_done,
   output logic micro_halt,
   output logic [23:0] main_exchange,
   // bench controls
   input wire halt_req,
   input wire [23:0] exch_val
);
   logic [1:0] ph_q;
   // ------------------------------------------------------------
   // one microinstruction every four cycles while running
   // ------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn || !run_enable) begin
         ph_q <= 2'h0;
      end else begin
         ph_q <= ph_q + 2'h1;
      end
   end
   assign micro_done = (ph_q == 2'h3);
   // halt op comes only when firmware decides, never from the irq bit
   assign micro_halt = halt_req;
   // exchange moves while running so stale lamps show up
   assign main_exchange = run_enable ? {22'h0, ph_q} ^ exch_val : exch_val;
endmodule // crhc_core_model

// *** tb/tb_crhc_console.sv ***
// self-checking bench for the console run/halt control block
`timescale 1ns/10ps
`include "crhc_defines.vh"
module tb_crhc_console;
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_rready, halt_req;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, rd;
   logic [3:0] s_axi_wstrb;
   logic [1:0] resp;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   logic [6:0] btn;
   wire interrupt_request_button, source_mode_button, clear_button;
   wire start_button, halt_button, load_button, inc_button;
   logic interrupt_toggle, single_step_select, micro_source_normal;
   logic cassette_to_processor, mem_parity_err, proc_parity_err;
   logic [23:0] data_switches, mem_parity_bits, proc_parity_bits;
   logic [23:0] exch_val, ld_cap;
   logic [3:0] group_select;
   logic [2:0] register_select;
   logic [6:0] tg_cap;
   wire [23:0] main_exchange, load_data, data_lamps;
   wire micro_done, micro_halt, run_enable, cassette_start;
   wire fetch_from_cassette, clear_pulse, load_pulse, inc_pulse;
   wire select_valid, interrupt_lamp, cassette_lamp, memory_lamp;
   wire test_state_lamp, state_lamp, run_lamp, error_lamp;
   wire [6:0] load_target;
   int err_count, cmp_count, cyc;
   int pc [5] = '{default:0};
   // rows: single step, source normal, expected test lamp
   logic [2:0] rows [4] = '{3'b111, 3'b001, 3'b101, 3'b010};

   assign {inc_button, load_button, halt_button, start_button,
      clear_button, source_mode_button, interrupt_request_button} = btn;
   crhc_console u_crhc_console (.*);
   crhc_core_model u_crhc_core_model (.*);

   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   // pulse counters; captures so one-cycle outputs are not missed
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (clear_pulse) pc[0] <= pc[0] + 1;
      if (load_pulse) pc[1] <= pc[1] + 1;
      if (inc_pulse) pc[2] <= pc[2] + 1;
      if (cassette_start) pc[3] <= pc[3] + 1;
      if (micro_done && run_enable) pc[4] <= pc[4] + 1;
      if (load_pulse) ld_cap <= load_data;
      if (load_pulse) tg_cap <= load_target;
      if (cyc == 20000) begin
         err_count++;
         summarize();
      end
   end
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // held well past the 125-cycle debounce, then released as long
   task automatic press(int i);
      btn[i] <= 1'b1;
      repeat (140) @(posedge aclk);
      btn[i] <= 1'b0;
      repeat (140) @(posedge aclk);
   endtask
   task automatic axw(logic [7:0] a, logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic axr(logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic summarize();
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
      {s_axi_arvalid, s_axi_rready, halt_req, btn} = 10'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hf;
      {interrupt_toggle, single_step_select, mem_parity_err} = 3'h0;
      {micro_source_normal, cassette_to_processor} = 2'h3;
      proc_parity_err = 1'b0;
      data_switches = 24'ha5c3f0;
      mem_parity_bits = 24'h000100;
      proc_parity_bits = 24'h000100;
      exch_val = 24'h5a3c96;
      group_select = 4'hf;
      register_select = 3'h6;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk("mem lamp", memory_lamp, 1);
      chk("err lamp", error_lamp, 0);
      axr(`CRHC_OFS_CTRL);
      chk("ctrl", rd, 0);
      foreach (rows[i]) begin
         single_step_select <= rows[i][2];
         micro_source_normal <= rows[i][1];
         repeat (140) @(posedge aclk);
         chk("test lamp", test_state_lamp, rows[i][0]);
      end
      chk("lamps", data_lamps, exch_val);
      // cassette source, single step with cassette start
      press(1);
      chk("cas lamp", cassette_lamp, 1);
      chk("fetch", fetch_from_cassette, 1);
      cassette_to_processor <= 1'b0;
      repeat (5) @(posedge aclk);
      chk("fetch off", fetch_from_cassette, 0);
      cassette_to_processor <= 1'b1;
      single_step_select <= 1'b1;
      press(3);
      chk("cas start", pc[3], 1);
      chk("one micro", pc[4], 1);
      chk("run lamp", run_lamp, 0);
      single_step_select <= 1'b0;
      press(1);
      chk("mem lamp", memory_lamp, 1);
      // free running, refused buttons, halt microinstruction
      press(3);
      chk("run lamp", run_lamp, 1);
      chk("cas start", pc[3], 1);
      press(2);
      press(5);
      chk("clear run", pc[0], 0);
      chk("load run", pc[1], 0);
      halt_req <= 1'b1;
      repeat (10) @(posedge aclk);
      chk("halted", run_enable, 0);
      halt_req <= 1'b0;
      press(3);
      press(4);
      chk("halt btn", run_lamp, 0);
      // parity errors cleared by load; load writes switches
      mem_parity_err <= 1'b1;
      proc_parity_err <= 1'b1;
      @(posedge aclk);
      mem_parity_err <= 1'b0;
      proc_parity_err <= 1'b0;
      repeat (2) @(posedge aclk);
      chk("err lamp", error_lamp, 1);
      axr(`CRHC_OFS_MEMORY_PARITY_ERROR_REGISTER);
      chk("memory_parity_error_register", rd, 32'h100);
      press(5);
      chk("err gone", error_lamp, 0);
      chk("load data", ld_cap, data_switches);
      chk("target", tg_cap, 7'h6f);
      axr(`CRHC_OFS_SEL);
      chk("sel reg", rd, 32'h000000ef);
      register_select <= 3'h7;
      repeat (2) @(posedge aclk);
      chk("sel bad", select_valid, 0);
      register_select <= 3'h6;
      press(6);
      chk("inc", pc[2], 1);
      press(2);
      chk("clear", pc[0], 1);
      // interrupt button, toggle and software clear
      press(0);
      chk("irq lamp", interrupt_lamp, 1);
      chk("test lamp", test_state_lamp, 1);
      axr(`CRHC_OFS_CTRL);
      chk("irq bit", rd[3], 1);
      axw(`CRHC_OFS_CTRL, 0);
      chk("sw clear", interrupt_lamp, 0);
      interrupt_toggle <= 1'b1;
      repeat (140) @(posedge aclk);
      chk("toggle", interrupt_lamp, 1);
      axw(`CRHC_OFS_CTRL, 0);
      repeat (140) @(posedge aclk);
      axr(`CRHC_OFS_CTRL);
      chk("reset again", rd[3], 1);
      interrupt_toggle <= 1'b0;
      repeat (140) @(posedge aclk);
      chk("toggle down", interrupt_lamp, 1);
      // state lamp follows control bit 0
      axw(`CRHC_OFS_CTRL, 1);
      chk("state on", state_lamp, 1);
      axw(`CRHC_OFS_CTRL, 0);
      chk("state off", state_lamp, 0);
      // unmapped read and read-only write
      axr(8'h20);
      chk("rresp", resp, `CRHC_RESP_ERR);
      chk("rdata", rd, 0);
      axw(`CRHC_OFS_STAT, 1);
      chk("bresp", resp, `CRHC_RESP_ERR);
      // reset in mid-run drops back to examine with memory source
      press(1);
      press(3);
      chk("run lamp", run_lamp, 1);
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk("rst run", run_lamp, 0);
      chk("rst src", memory_lamp, 1);
      chk("rst fetch", fetch_from_cassette, 0);
      summarize();
   end
endmodule // tb_crhc_console
